// ===== src/psf_defs.vh
// constants for the predriver serial control and fault port
`ifndef PSF_DEFS_VH
`define PSF_DEFS_VH
`define PSF_NUM_CH        4
`define PSF_GATE_RST      4'h0
`define PSF_SHIFT_RST     4'h0
`define PSF_FAULT_RST     4'h0
`define PSF_MSB_CH        3
`define PSF_SEL_INTERNAL  1'h0
`define PSF_SEL_EXTERNAL  1'h1
`endif

// ===== src/psf_serial_port.v
// serial control and fault reporting port of a four-channel low-side predriver
// What this block does
// - falling reset input clears all registers but the synchronisers and edge history, gates off, fault flag released
// - shift register advances on falling serial clock: sample input, shift out next
// - control bit 1 turns its gate on, 0 turns it off
// - serial output is three-state and shifts captured fault status to the host
// - serial output forwards shifted-in bits onward for daisy chaining
// - chip select high keeps serial output in high impedance
// - reference select 0 picks internal reference, 1 picks external, both fault kinds
// - chip select falling enables output, loads fault status, refreshes fault flag
// - chip select rising moves shifted control bits into the gate control register
// - fault registers update while deselected, snapshot frozen while selected
// - open-drain wire-or fault flag in real time for load and battery faults
`timescale 1ns/1ps
`include "psf_defs.vh"

module psf_serial_port (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       reset_n,
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       serial_in,
  input  wire       ref_select,
  input  wire [3:0] short_int_det,
  input  wire [3:0] short_ext_det,
  input  wire [3:0] open_int_det,
  input  wire [3:0] open_ext_det,
  input  wire       bat_volt_fault,
  output reg  [3:0] gate_outputs,
  output reg        serial_out,
  output reg        serial_out_oe_n,
  output reg        fault_flag_n_out,
  output reg        fault_flag_n_oe_n
);

  // first synchroniser stages; only the matching second stage reads them
  reg        rstn_meta_reg;
  reg        cs_meta_reg;
  reg        sclk_meta_reg;
  reg        sdi_meta_reg;
  reg        sel_meta_reg;
  reg        bat_meta_reg;
  reg  [3:0] short_int_meta_reg;
  reg  [3:0] short_ext_meta_reg;
  reg  [3:0] open_int_meta_reg;
  reg  [3:0] open_ext_meta_reg;

  // second synchroniser stages; the only copies the logic may read
  reg        rstn_sync_reg;
  reg        cs_sync_reg;
  reg        sclk_sync_reg;
  reg        sdi_sync_reg;
  reg        sel_sync_reg;
  reg        bat_sync_reg;
  reg  [3:0] short_int_sync_reg;
  reg  [3:0] short_ext_sync_reg;
  reg  [3:0] open_int_sync_reg;
  reg  [3:0] open_ext_sync_reg;

  // previous synchronised levels, kept for edge finding
  reg        rstn_prev_reg;
  reg        cs_prev_reg;
  reg        sclk_prev_reg;

  // shift chain, fault source for the snapshot and the latched flag part
  reg  [3:0] shift_reg;
  reg  [3:0] fault_reg;
  reg        flag_latch_reg;

  // next values worked out by the combinational block
  reg  [3:0] shift_next;
  reg  [3:0] fault_next;
  reg        flag_latch_next;
  reg  [3:0] gate_next;
  reg        serial_next;
  reg        serial_oe_n_next;
  reg        flag_oe_n_next;

  // decoded edges and fault summaries
  wire       rst_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       sclk_fall;
  wire [3:0] short_sel;
  wire [3:0] open_sel;
  wire [3:0] chan_flt;
  wire       live_fault;

  // reference choice
  // one selector serves both the shorted and the open comparator sets
  function [3:0] pick_ref;
    input       sel;
    input [3:0] int_det;
    input [3:0] ext_det;
    begin
      if (sel == `PSF_SEL_EXTERNAL) begin
        pick_ref = ext_det;
      end else begin
        pick_ref = int_det;
      end
    end
  endfunction

  // reset pin; a pulse shorter than one clock may be missed
  always @(posedge clk_sys) begin
    rstn_meta_reg <= reset_n;
    rstn_sync_reg <= rstn_meta_reg;
  end

  // chip select pin
  always @(posedge clk_sys) begin
    cs_meta_reg <= cs_n;
    cs_sync_reg <= cs_meta_reg;
  end

  // serial clock pin; sampling limits the usable link rate
  always @(posedge clk_sys) begin
    sclk_meta_reg <= sclk;
    sclk_sync_reg <= sclk_meta_reg;
  end

  // serial data pin, same delay as the clock so they stay aligned
  always @(posedge clk_sys) begin
    sdi_meta_reg <= serial_in;
    sdi_sync_reg <= sdi_meta_reg;
  end

  // reference select pin
  always @(posedge clk_sys) begin
    sel_meta_reg <= ref_select;
    sel_sync_reg <= sel_meta_reg;
  end

  // battery voltage fault
  always @(posedge clk_sys) begin
    bat_meta_reg <= bat_volt_fault;
    bat_sync_reg <= bat_meta_reg;
  end

  // shorted-load detections, internal reference
  always @(posedge clk_sys) begin
    short_int_meta_reg <= short_int_det;
    short_int_sync_reg <= short_int_meta_reg;
  end

  // shorted-load detections, external reference
  always @(posedge clk_sys) begin
    short_ext_meta_reg <= short_ext_det;
    short_ext_sync_reg <= short_ext_meta_reg;
  end

  // open-load detections, internal reference
  always @(posedge clk_sys) begin
    open_int_meta_reg <= open_int_det;
    open_int_sync_reg <= open_int_meta_reg;
  end

  // open-load detections, external reference
  always @(posedge clk_sys) begin
    open_ext_meta_reg <= open_ext_det;
    open_ext_sync_reg <= open_ext_meta_reg;
  end

  // edge history; idle levels at reset avoid a false edge after it
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rstn_prev_reg <= 1'h1;
      cs_prev_reg   <= 1'h1;
      sclk_prev_reg <= 1'h1;
    end else begin
      rstn_prev_reg <= rstn_sync_reg;
      cs_prev_reg   <= cs_sync_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  assign rst_fall   = rstn_prev_reg & ~rstn_sync_reg;
  assign cs_fall    = cs_prev_reg & ~cs_sync_reg;
  assign cs_rise    = ~cs_prev_reg & cs_sync_reg;
  // serial clock falls count only while selected
  assign sclk_fall  = sclk_prev_reg & ~sclk_sync_reg & ~cs_sync_reg;

  // selected detections; a channel faults on short or open
  assign short_sel  = pick_ref(sel_sync_reg, short_int_sync_reg, short_ext_sync_reg);
  assign open_sel   = pick_ref(sel_sync_reg, open_int_sync_reg, open_ext_sync_reg);
  assign chan_flt   = short_sel | open_sel;
  // any live load fault or battery fault
  assign live_fault = (|chan_flt) | bat_sync_reg;

  // next state of the serial port
  always @* begin
    shift_next       = shift_reg;
    fault_next       = fault_reg;
    flag_latch_next  = flag_latch_reg;
    gate_next        = gate_outputs;
    serial_next      = serial_out;
    serial_oe_n_next = serial_out_oe_n;
    // real-time flag
    // the latched part holds the snapshot's fault summary until the next chip select fall or reset
    flag_oe_n_next   = ~(flag_latch_reg | live_fault);
    if (cs_sync_reg) begin
      fault_next = chan_flt;
    end
    if (cs_fall) begin
      shift_next       = fault_reg;
      flag_latch_next  = |fault_reg;
      serial_next      = fault_reg[`PSF_MSB_CH];
      serial_oe_n_next = 1'h0;
    end else if (sclk_fall) begin
      shift_next  = {shift_reg[`PSF_MSB_CH-1:0], sdi_sync_reg};
      serial_next = shift_reg[`PSF_MSB_CH-1];
    end
    if (cs_sync_reg) begin
      serial_oe_n_next = 1'h1;
    end
    if (cs_rise) begin
      gate_next = shift_reg;
    end
  end

  // registers; every output leaves straight from a flop
  always @(posedge clk_sys) begin
    if (sys_rst || rst_fall) begin
      shift_reg         <= `PSF_SHIFT_RST;
      fault_reg         <= `PSF_FAULT_RST;
      flag_latch_reg    <= 1'h0;
      gate_outputs      <= `PSF_GATE_RST;
      serial_out        <= 1'h0;
      serial_out_oe_n   <= 1'h1;
      fault_flag_n_out  <= 1'h0;
      fault_flag_n_oe_n <= 1'h1;
    end else begin
      shift_reg         <= shift_next;
      fault_reg         <= fault_next;
      flag_latch_reg    <= flag_latch_next;
      gate_outputs      <= gate_next;
      serial_out        <= serial_next;
      serial_out_oe_n   <= serial_oe_n_next;
      // open drain: the pad only ever pulls low
      fault_flag_n_out  <= 1'h0;
      fault_flag_n_oe_n <= flag_oe_n_next;
    end
  end

endmodule

// ===== test/psf_properties.sv
// checker for the serial fault port
`timescale 1ns/1ps
module psf_props (input wire clk_sys, sys_rst, reset_n, cs_n, sclk, ref_select, bat_volt_fault, serial_out,
  input wire serial_out_oe_n, fault_flag_n_out, fault_flag_n_oe_n,
  input wire [3:0] short_int_det, short_ext_det, open_int_det, open_ext_det, gate_outputs);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rst_gates: assert property ($fell(reset_n) |-> ##[2:6] !gate_outputs) else $error("gates");
  a_flag_drain: assert property (!fault_flag_n_out) else $error("drain");
  a_idle_hiz: assert property ($rose(cs_n) |-> ##[1:5] serial_out_oe_n) else $error("hiz");
  a_sel_drive: assert property ($fell(cs_n) |-> ##[1:5] !serial_out_oe_n) else $error("drive");
  a_gate_hold: assert property (!cs_n [*8] |-> $stable(gate_outputs)) else $error("hold");
  a_bit_hold: assert property ((!cs_n && sclk) [*6] |-> $stable(serial_out)) else $error("bit");
  a_bat_flag: assert property (bat_volt_fault [*5] |-> !fault_flag_n_oe_n) else $error("bat");
  a_ref_flag: assert property ((cs_n &&
    |(ref_select ? short_ext_det | open_ext_det : short_int_det | open_int_det)) [*5] |-> !fault_flag_n_oe_n)
    else $error("ref");
endmodule
bind psf_serial_port psf_props u_chk (.*);

// ===== test/psf_host.sv
// host model that runs frames on the serial link
`timescale 1ns/1ps
module psf_host (input wire clk_sys, serial_out, output reg cs_n = 1'h1, sclk = 1'h1, serial_in = 1'h0);
  task w;
    repeat (8) @(posedge clk_sys);
  endtask
  // ch3 first, bit set on the rise, taken on the fall; 160 ns period
  task xfer(input [3:0] d, output [4:0] q);
    integer i;
    begin
      cs_n <= 1'h0;
      for (i = 4; i > 0; i = i - 1) begin
        serial_in <= d[i - 1];
        w; q[i] = serial_out; sclk <= 1'h0;
        w; sclk <= 1'h1;
      end
      q[0] = serial_out; // forwarded first bit
      cs_n <= 1'h1;
      serial_in <= ~serial_in; // no stale data between frames
    end
  endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the serial fault port
`timescale 1ns/1ps
module tb_top;
  reg clk_sys = 1'h0, sys_rst = 1'h1, reset_n = 1'h1, ref_select = 1'h0, bat_volt_fault = 1'h0;
  reg [3:0] short_int_det = 4'h5, short_ext_det = 4'h2, open_int_det = 4'h0, open_ext_det = 4'h1, d;
  wire cs_n, sclk, serial_in, serial_out, serial_out_oe_n, fault_flag_n_out, fault_flag_n_oe_n;
  wire [3:0] gate_outputs;
  reg [4:0] q;
  integer num_errors = 0, n_tests = 0, i;
  always #5 clk_sys = ~clk_sys;
  psf_host host_u (.*);
  psf_serial_port dut_u (.*);
  task check(input [4:0] got, exp);
    begin n_tests = n_tests + 1;
      if (got !== exp) begin num_errors = num_errors + 1; $display("Error at %0t got %h exp %h", $time, got, exp); end
    end
  endtask
  task wrap_up;
    begin $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish; end
  endtask
  // internal then external reference; the unselected detections must not leak
  task t_refs;
    for (i = 0; i < 2; i = i + 1) begin
      ref_select <= i[0]; d = 4'hA >> i; host_u.w; host_u.xfer(d, q); host_u.w;
      check(q, {i ? 4'h3 : 4'h5, d[3]});
      check({gate_outputs, serial_out_oe_n}, {d, 1'h1});
    end
    $display("refs done");
  endtask
  // detections cleared first so only the latched flag and the battery fault remain
  task t_reset;
    {short_int_det, short_ext_det, open_ext_det} <= 12'h000; reset_n <= 1'h0; host_u.w;
    reset_n <= 1'h1; host_u.w; check({gate_outputs, fault_flag_n_oe_n}, 5'h01);
    bat_volt_fault <= 1'h1; host_u.w; check(fault_flag_n_oe_n, 1'h0);
    bat_volt_fault <= 1'h0; host_u.w; check(fault_flag_n_oe_n, 1'h1);
    $display("reset done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0; host_u.w; check({gate_outputs, serial_out_oe_n}, 5'h01);
    t_refs; t_reset; wrap_up;
  end
  // the tests need well under 10 us
  initial begin #20000; num_errors = num_errors + 1; wrap_up; end
endmodule
